// ---- logic/pv_cond_pkg.sv ----
package pv_cond_pkg;
	// ==========================================
	// Input classes
	typedef enum logic [1:0] {
		CLASS_TC,
		CLASS_RTD,
		CLASS_VOLT,
		CLASS_CURR
	} input_class_t;

	// ==========================================
	// Reset values of setup settings
	localparam logic        UNIT_RESET       = 1'b0;
	localparam logic        CJC_RESET        = 1'b0;
	localparam logic [9:0]  DROPOUT_RESET    = 10'h000;
	localparam logic [1:0]  DECIMAL_RESET    = 2'h0;
	localparam logic signed [15:0] SCALE_LO_RESET = 16'sh0000;
	localparam logic signed [15:0] SCALE_HI_RESET = 16'sh03e8;
	localparam logic [13:0] RATIO_RESET      = 14'h03e8;
	localparam logic signed [15:0] BIAS_RESET = 16'sh0000;
	localparam logic        UNDER_RESET      = 1'b0;

	// ==========================================
	// Limits and special numbers
	localparam logic signed [15:0] SETTING_MIN = -16'sd1999;
	localparam logic signed [15:0] SETTING_MAX = 16'sd9999;
	localparam logic [13:0] RATIO_MIN        = 14'd1;
	localparam logic [13:0] RATIO_MAX        = 14'd9999;
	localparam logic [13:0] RATIO_ONE        = 14'd1000;
	localparam logic [9:0]  DROPOUT_MAX      = 10'd1000;
	localparam logic signed [15:0] PCT_FULL  = 16'sd1000;
	localparam logic signed [15:0] PCT_LOW   = -16'sd100;
	localparam logic signed [15:0] PCT_HIGH  = 16'sd1100;
	localparam logic [7:0]  RANGE_NO_DP      = 8'd3;
	localparam logic [7:0]  RANGE_UNDER_A    = 8'd17;
	localparam logic [7:0]  RANGE_UNDER_B    = 8'd23;
	localparam logic signed [15:0] MV5_THRESH = -16'sd50;
	localparam logic signed [15:0] ZERO_TEMP = 16'sd0;

	// ==========================================
	// Sampling cycle
	localparam int SAMPLE_MS     = 500;
	localparam int CLK_HZ        = 50000000;
	localparam int SAMPLE_CYCLES = CLK_HZ / 1000 * SAMPLE_MS;

	// ==========================================
	// Carriers
	typedef struct packed {
		logic         [7:0]  range_number;
		input_class_t        in_class;
		logic                temp_unit;
		logic                cjc_external;
		logic         [9:0]  dropout;
		logic         [1:0]  decimal_pos;
		logic signed  [15:0] scale_lo;
		logic signed  [15:0] scale_hi;
		logic         [13:0] ratio_factor;
		logic signed  [15:0] bias_term;
		logic                under_mv;
	} setup_t;

	typedef struct packed {
		logic signed [15:0] value;
		logic               cjc_internal;
		logic               fahrenheit;
		logic        [1:0]  decimal_pos;
		logic               low_limit_alarm_flag;
		logic               high_limit_alarm_flag;
	} pv_word_t;
endpackage

// ---- logic/pv_input_conditioning.sv ----
`timescale 1ns/1ps
// How it works
// - Unit select for temperature classes, default Celsius
// - Thermocouple compensation internal or external, default internal
// - Dropout 0.1-100.0 percent; zero disables root
// - Between dropout and 100: sqrt scaled
// - Above zero below dropout: output zero
// - Outside zero to 100: pass through
// - Root only for voltage and current classes
// - Decimal position zero to three, default none
// - Decimal change carried to dependent parameters
// - Range three forces decimal position zero
// - Scaling limits -1999 to 9999, default 0/1000
// - Temperature classes use range-table limits, read-only
// - Output is input times ratio plus bias
// - Under-range type picks alarm threshold, ranges 17/23
// - Range 23 with millivolt threshold clamps at zero
// - PV clamped between -10 and 110 percent
// - Limit alarms judged before ratio and bias
// - One sample per half second
module pv_input_conditioning #(
	parameter int SAMPLE_CYCLES = pv_cond_pkg::SAMPLE_CYCLES
) (
	input  wire logic                  core_clk,
	input  wire logic                  sys_rst,
	input  wire logic                  clk_en,
	input  wire pv_cond_pkg::setup_t   setup,
	input  wire logic                  setup_write,
	input  wire logic signed [15:0]    table_lo,
	input  wire logic signed [15:0]    table_hi,
	input  wire logic signed [15:0]    raw_pct,
	input  wire logic                  raw_valid,
	output logic                       raw_ready,
	output pv_cond_pkg::pv_word_t      pv_out,
	output logic                       pv_valid,
	input  wire logic                  pv_ready,
	output logic [1:0]                 active_decimal,
	output logic signed [15:0]         active_scale_lo,
	output logic signed [15:0]         active_scale_hi
);
	// ==========================================
	// Helpers
	function automatic logic signed [15:0] clip_setting(input logic signed [15:0] v);
		if (v < pv_cond_pkg::SETTING_MIN) begin
			return pv_cond_pkg::SETTING_MIN;
		end else if (v > pv_cond_pkg::SETTING_MAX) begin
			return pv_cond_pkg::SETTING_MAX;
		end
		return v;
	endfunction

	function automatic logic signed [15:0] clamp(input logic signed [31:0] v,
			input logic signed [15:0] lo, input logic signed [15:0] hi);
		if (v < 32'(lo)) begin
			return lo;
		end else if (v > 32'(hi)) begin
			return hi;
		end
		return v[15:0];
	endfunction

	// Bitwise integer root; fine for the 20-bit argument here
	function automatic logic [15:0] isqrt(input logic [31:0] v);
		logic [31:0] rem;
		logic [31:0] res;
		logic [31:0] bitv;
		rem = v;
		res = 32'h0;
		bitv = 32'h40000000;
		for (int i = 0; i < 16; i++) begin
			if (rem >= res + bitv) begin
				rem = rem - (res + bitv);
				res = (res >> 1) + bitv;
			end else begin
				res = res >> 1;
			end
			bitv = bitv >> 2;
		end
		return res[15:0];
	endfunction

	function automatic logic is_temp(input pv_cond_pkg::input_class_t c);
		return (c == pv_cond_pkg::CLASS_TC) || (c == pv_cond_pkg::CLASS_RTD);
	endfunction

	// ==========================================
	// Setup registers
	logic                  unit_reg, unit_next;
	logic                  cjc_reg, cjc_next;
	logic [9:0]            drop_reg, drop_next;
	logic [1:0]            dec_reg, dec_next;
	logic signed [15:0]    slo_reg, slo_next;
	logic signed [15:0]    shi_reg, shi_next;
	logic [13:0]           ratio_reg, ratio_next;
	logic signed [15:0]    bias_reg, bias_next;
	logic                  under_reg, under_next;
	logic [7:0]            range_reg, range_next;
	pv_cond_pkg::input_class_t cls_reg, cls_next;

	always_comb begin
		unit_next = unit_reg;
		cjc_next = cjc_reg;
		drop_next = drop_reg;
		dec_next = dec_reg;
		slo_next = slo_reg;
		shi_next = shi_reg;
		ratio_next = ratio_reg;
		bias_next = bias_reg;
		under_next = under_reg;
		range_next = range_reg;
		cls_next = cls_reg;
		if (setup_write) begin
			range_next = setup.range_number;
			cls_next = setup.in_class;
			if (is_temp(setup.in_class)) begin
				unit_next = setup.temp_unit;
			end
			if (setup.in_class == pv_cond_pkg::CLASS_TC) begin
				cjc_next = setup.cjc_external;
			end
			if (!is_temp(setup.in_class)) begin
				// Out-of-range dropout is saturated, not rejected
				drop_next = (setup.dropout > pv_cond_pkg::DROPOUT_MAX) ?
					pv_cond_pkg::DROPOUT_MAX : setup.dropout;
				slo_next = clip_setting(setup.scale_lo);
				shi_next = clip_setting(setup.scale_hi);
			end
			dec_next = setup.decimal_pos;
			if (setup.ratio_factor < pv_cond_pkg::RATIO_MIN) begin
				ratio_next = pv_cond_pkg::RATIO_MIN;
			end else if (setup.ratio_factor > pv_cond_pkg::RATIO_MAX) begin
				ratio_next = pv_cond_pkg::RATIO_MAX;
			end else begin
				ratio_next = setup.ratio_factor;
			end
			bias_next = clip_setting(setup.bias_term);
			under_next = setup.under_mv;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			unit_reg <= pv_cond_pkg::UNIT_RESET;
			cjc_reg <= pv_cond_pkg::CJC_RESET;
			drop_reg <= pv_cond_pkg::DROPOUT_RESET;
			dec_reg <= pv_cond_pkg::DECIMAL_RESET;
			slo_reg <= pv_cond_pkg::SCALE_LO_RESET;
			shi_reg <= pv_cond_pkg::SCALE_HI_RESET;
			ratio_reg <= pv_cond_pkg::RATIO_RESET;
			bias_reg <= pv_cond_pkg::BIAS_RESET;
			under_reg <= pv_cond_pkg::UNDER_RESET;
			range_reg <= 8'h00;
			cls_reg <= pv_cond_pkg::CLASS_VOLT;
		end else if (clk_en) begin
			unit_reg <= unit_next;
			cjc_reg <= cjc_next;
			drop_reg <= drop_next;
			dec_reg <= dec_next;
			slo_reg <= slo_next;
			shi_reg <= shi_next;
			ratio_reg <= ratio_next;
			bias_reg <= bias_next;
			under_reg <= under_next;
			range_reg <= range_next;
			cls_reg <= cls_next;
		end
	end

	// ==========================================
	// Effective settings
	logic               temp_cls;
	logic [1:0]         eff_dec;
	logic signed [15:0] eff_lo;
	logic signed [15:0] eff_hi;
	always_comb begin
		temp_cls = is_temp(cls_reg);
		eff_dec = (range_reg == pv_cond_pkg::RANGE_NO_DP) ? 2'h0 : dec_reg;
		eff_lo = temp_cls ? table_lo : slo_reg;
		eff_hi = temp_cls ? table_hi : shi_reg;
	end

	// ==========================================
	// Sample tick and datapath
	logic [31:0] tick_reg, tick_next;
	logic        take;
	logic signed [15:0] sq_pct;
	logic signed [31:0] scaled;
	logic signed [15:0] pv_clamped;
	logic signed [31:0] corrected;
	logic               lo_alarm;
	logic               hi_alarm;
	logic               under_sel;
	pv_cond_pkg::pv_word_t word;
	logic signed [15:0] pct_lim;

	always_comb begin
		tick_next = (tick_reg == 32'(SAMPLE_CYCLES - 1)) ? 32'h0 : tick_reg + 32'h1;
		// Taking only against the registered ready keeps the first edge after reset honest
		take = raw_valid && raw_ready;
		// Percent clamp; the -5 mV choice lets low readings through without alarm only down to -50
		under_sel = under_reg && ((range_reg == pv_cond_pkg::RANGE_UNDER_A) ||
			(range_reg == pv_cond_pkg::RANGE_UNDER_B));
		pct_lim = clamp(32'(raw_pct), pv_cond_pkg::PCT_LOW, pv_cond_pkg::PCT_HIGH);
		lo_alarm = under_sel ? (raw_pct < pv_cond_pkg::MV5_THRESH) :
			(raw_pct < pv_cond_pkg::PCT_LOW);
		hi_alarm = raw_pct > pv_cond_pkg::PCT_HIGH;
		sq_pct = pct_lim;
		if (!temp_cls && drop_reg != 10'h000 && pct_lim > 16'sd0 &&
				pct_lim < pv_cond_pkg::PCT_FULL) begin
			if (pct_lim < $signed({6'h00, drop_reg})) begin
				sq_pct = 16'sd0;
			end else begin
				sq_pct = $signed(isqrt(32'(pct_lim) * 32'd1000));
			end
		end
		scaled = 32'(eff_lo) + (32'(sq_pct) * (32'(eff_hi) - 32'(eff_lo))) / 32'sd1000;
		pv_clamped = scaled[15:0];
		if (under_reg && range_reg == pv_cond_pkg::RANGE_UNDER_B &&
				pv_clamped < pv_cond_pkg::ZERO_TEMP) begin
			pv_clamped = pv_cond_pkg::ZERO_TEMP;
		end
		// Ratio is widened as a signed operand so negative readings divide correctly
		corrected = (32'(pv_clamped) * $signed(32'(ratio_reg))) / 32'sd1000 +
			32'(bias_reg);
		word.value = clamp(corrected, -16'sh7fff, 16'sh7fff);
		word.cjc_internal = !cjc_reg && cls_reg == pv_cond_pkg::CLASS_TC;
		word.fahrenheit = unit_reg && temp_cls;
		word.decimal_pos = eff_dec;
		word.low_limit_alarm_flag = lo_alarm;
		word.high_limit_alarm_flag = hi_alarm;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			tick_reg <= 32'h0;
		end else if (clk_en) begin
			tick_reg <= tick_next;
		end
	end

	// ==========================================
	// Two-entry output buffer; a stalled receiver backs up into raw_ready
	pv_cond_pkg::pv_word_t buf_reg [2];
	pv_cond_pkg::pv_word_t buf_next [2];
	logic [1:0] cnt_reg, cnt_next;
	logic       buf_room;
	logic       pop;
	always_comb begin
		buf_room = cnt_reg != 2'd2;
		pop = pv_ready && cnt_reg != 2'd0;
		buf_next = buf_reg;
		cnt_next = cnt_reg;
		if (pop) begin
			buf_next[0] = buf_reg[1];
			cnt_next = cnt_next - 2'd1;
		end
		if (take) begin
			buf_next[cnt_next[0]] = word;
			cnt_next = cnt_next + 2'd1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cnt_reg <= 2'd0;
			buf_reg[0] <= '0;
			buf_reg[1] <= '0;
			raw_ready <= 1'b0;
			pv_out <= '0;
			pv_valid <= 1'b0;
			active_decimal <= pv_cond_pkg::DECIMAL_RESET;
			active_scale_lo <= pv_cond_pkg::SCALE_LO_RESET;
			active_scale_hi <= pv_cond_pkg::SCALE_HI_RESET;
		end else if (clk_en) begin
			cnt_reg <= cnt_next;
			buf_reg <= buf_next;
			raw_ready <= (tick_next == 32'h0) && (cnt_next != 2'd2);
			pv_out <= buf_next[0];
			pv_valid <= cnt_next != 2'd0;
			active_decimal <= eff_dec;
			active_scale_lo <= eff_lo;
			active_scale_hi <= eff_hi;
		end
	end
endmodule

// ---- testbench/pv_cond_properties.sv ----
`timescale 1ns/1ps
module pv_cond_properties #(
	parameter int SAMPLE_CYCLES = 8
) (
	input wire logic                  core_clk,
	input wire logic                  sys_rst,
	input wire pv_cond_pkg::setup_t   setup,
	input wire logic                  setup_write,
	input wire logic signed [15:0]    raw_pct,
	input wire logic                  raw_valid,
	input wire logic                  raw_ready,
	input wire pv_cond_pkg::pv_word_t pv_out,
	input wire logic                  pv_valid,
	input wire logic                  pv_ready,
	input wire logic [1:0]            active_decimal,
	input wire logic signed [15:0]    active_scale_lo
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// ==========
	// Cycles since raw_ready was last high; saturates so long gaps never wrap
	int gap_reg;
	int gap_next;
	wire logic volt_w = setup_write && setup.in_class == pv_cond_pkg::CLASS_VOLT;
	always_comb begin
		gap_next = (gap_reg < SAMPLE_CYCLES) ? gap_reg + 1 : gap_reg;
		if (raw_ready) begin
			gap_next = 0;
		end
	end
	always_ff @(posedge core_clk) begin
		gap_reg <= sys_rst ? SAMPLE_CYCLES : gap_next;
	end
	sequence take_s;
		raw_ready && raw_valid && !pv_valid;
	endsequence
	// ==========
	take_answer_a: assert property (raw_ready && raw_valid |=> pv_valid)
		else $error("no word after take");
	take_spacing_a: assert property (raw_ready |-> gap_reg >= SAMPLE_CYCLES - 1)
		else $error("takes too close");
	word_holds_a: assert property (pv_valid && !pv_ready |=> pv_valid && $stable(pv_out))
		else $error("word lost in stall");
	low_alarm_a: assert property (
		take_s ##0 (raw_pct < pv_cond_pkg::PCT_LOW) |=> pv_out.low_limit_alarm_flag)
		else $error("low alarm missing");
	high_alarm_a: assert property (
		take_s ##0 (raw_pct > pv_cond_pkg::PCT_HIGH) |=> pv_out.high_limit_alarm_flag)
		else $error("high alarm missing");
	range_three_a: assert property (
		setup_write && setup.range_number == pv_cond_pkg::RANGE_NO_DP
		|-> ##2 active_decimal == 2'h0)
		else $error("range three kept decimals");
	decimal_load_a: assert property (
		volt_w && setup.range_number != pv_cond_pkg::RANGE_NO_DP
		|-> ##2 active_decimal == $past(setup.decimal_pos, 2))
		else $error("decimal not loaded");
	scale_load_a: assert property (
		volt_w && setup.scale_lo inside {[pv_cond_pkg::SETTING_MIN:pv_cond_pkg::SETTING_MAX]}
		|-> ##2 active_scale_lo == $past(setup.scale_lo, 2))
		else $error("scale low not loaded");
endmodule

// ---- testbench/pv_sensor_model.sv ----
`timescale 1ns/1ps
module pv_sensor_model (
	input wire logic           core_clk,
	input wire logic           raw_ready,
	output logic signed [15:0] raw_pct,
	output logic               raw_valid
);
	initial begin
		raw_pct = 16'sh0000;
		raw_valid = 1'b0;
	end
	// ==========
	// Holds a sample until taken or bound cycles pass; a released line shows the inverse so stale data is caught
	task automatic offer(input logic signed [15:0] pct, input int bound, output logic taken);
		taken = 1'b0;
		@(posedge core_clk);
		raw_pct <= pct;
		raw_valid <= 1'b1;
		for (int i = 0; i < bound && !taken; i++) begin
			@(posedge core_clk);
			taken = raw_ready;
		end
		raw_valid <= 1'b0;
		raw_pct <= ~pct;
	endtask
endmodule

// ---- testbench/pv_input_conditioning_tb.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
	$display("[ERR] %0t %h %h", $time, a, b); end end
module pv_input_conditioning_tb;
	logic                  core_clk = 1'b0;
	logic                  sys_rst = 1'b1;
	logic                  setup_write = 1'b0;
	logic                  pv_ready = 1'b1;
	logic signed [15:0]    table_lo = 16'sh0000;
	logic signed [15:0]    table_hi = 16'sh03e8;
	pv_cond_pkg::setup_t   setup = '0;
	pv_cond_pkg::pv_word_t pv_out;
	logic                  raw_ready, raw_valid, pv_valid;
	logic signed [15:0]    raw_pct, active_scale_lo, active_scale_hi;
	logic [1:0]            active_decimal;
	int                    err_total = 0;
	int                    checks_done = 0;
	always #10 core_clk = ~core_clk;
	// Short tick keeps the run brief; every expectation is count-free
	pv_input_conditioning #(.SAMPLE_CYCLES(8)) dut (.core_clk, .sys_rst, .clk_en(1'b1),
		.setup, .setup_write, .table_lo, .table_hi, .raw_pct, .raw_valid, .raw_ready,
		.pv_out, .pv_valid, .pv_ready, .active_decimal, .active_scale_lo, .active_scale_hi);
	pv_sensor_model src (.core_clk, .raw_ready, .raw_pct, .raw_valid);
	// ==========
	task automatic report_and_stop();
		if (err_total == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic apply(input pv_cond_pkg::input_class_t c, input logic [7:0] rn,
		input logic [9:0] dro, input logic signed [15:0] lo, hi, input logic [13:0] ra,
		input logic signed [15:0] bi, input logic um);
		@(posedge core_clk);
		setup <= '{rn, c, 1'b1, 1'b0, dro, 2'h2, lo, hi, ra, bi, um};
		setup_write <= 1'b1;
		@(posedge core_clk);
		setup_write <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic wait_word();
		int n;
		n = 0;
		@(posedge core_clk);
		while (pv_valid !== 1'b1) begin
			n++;
			if (n == 40) begin
				err_total++;
				report_and_stop();
			end
			@(posedge core_clk);
		end
	endtask
	task automatic run(input logic signed [15:0] pct, exp);
		logic got;
		src.offer(pct, 40, got);
		`CHK(got, 1'b1)
		if (got !== 1'b1) begin
			report_and_stop();
		end
		wait_word();
		`CHK(pv_out.value, exp)
	endtask
	// ==========
	task automatic t_reset();
		`CHK(active_scale_hi, pv_cond_pkg::SCALE_HI_RESET)
		`CHK(active_decimal, pv_cond_pkg::DECIMAL_RESET)
	endtask
	task automatic t_volt();
		apply(pv_cond_pkg::CLASS_VOLT, 8'd81, 10'h0, 16'sd0, 16'sd1000, 14'd1000, 16'sd0, 1'b0);
		run(16'sd500, 16'sd500);
		`CHK(pv_out.decimal_pos, 2'h2)
		run(16'sd1200, 16'sd1100);
		`CHK(pv_out.high_limit_alarm_flag, 1'b1)
		run(-16'sd150, -16'sd100);
		`CHK(pv_out.low_limit_alarm_flag, 1'b1)
		apply(pv_cond_pkg::CLASS_VOLT, 8'd81, 10'h0, 16'sd0, 16'sd1000, 14'd2000, 16'sd7, 1'b0);
		run(16'sd300, 16'sd607);
		apply(pv_cond_pkg::CLASS_VOLT, 8'd81, 10'h0, -16'sd200, 16'sd1800, 14'd1000, 16'sd0, 1'b0);
		run(16'sd250, 16'sd300);
	endtask
	task automatic t_root();
		apply(pv_cond_pkg::CLASS_VOLT, 8'd81, 10'd100, 16'sd0, 16'sd1000, 14'd1000, 16'sd0, 1'b0);
		run(16'sd250, 16'sd500);
		run(16'sd50, 16'sd0);
		run(16'sd1000, 16'sd1000);
		run(-16'sd20, -16'sd20);
	endtask
	task automatic t_temp();
		table_lo <= -16'sd100;
		apply(pv_cond_pkg::CLASS_TC, 8'd17, 10'd100, 16'sd500, 16'sd600, 14'd1000, 16'sd0, 1'b0);
		run(16'sd250, 16'sd175);
		`CHK(pv_out.fahrenheit, 1'b1)
		`CHK(pv_out.cjc_internal, 1'b1)
		`CHK(active_scale_lo, -16'sd100)
		apply(pv_cond_pkg::CLASS_TC, 8'd23, 10'd0, 16'sd0, 16'sd1000, 14'd1000, 16'sd0, 1'b1);
		run(-16'sd70, 16'sd0);
		`CHK(pv_out.low_limit_alarm_flag, 1'b1)
	endtask
	task automatic t_decimal();
		apply(pv_cond_pkg::CLASS_TC, 8'd3, 10'd0, 16'sd0, 16'sd1000, 14'd1000, 16'sd0, 1'b0);
		@(posedge core_clk);
		`CHK(active_decimal, 2'h0)
		apply(pv_cond_pkg::CLASS_VOLT, 8'd81, 10'd0, 16'sd0, 16'sd1000, 14'd1000, 16'sd0, 1'b0);
		@(posedge core_clk);
		`CHK(active_decimal, 2'h2)
	endtask
	task automatic t_stall();
		logic got;
		pv_ready <= 1'b0;
		src.offer(16'sd100, 40, got);
		src.offer(16'sd200, 40, got);
		`CHK(got, 1'b1)
		src.offer(16'sd300, 20, got);
		`CHK(got, 1'b0)
		pv_ready <= 1'b1;
		wait_word();
		`CHK(pv_out.value, 16'sd100)
		wait_word();
		`CHK(pv_out.value, 16'sd200)
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		sys_rst <= 1'b0;
		t_reset();
		t_volt();
		t_root();
		t_temp();
		t_decimal();
		t_stall();
		report_and_stop();
	end
endmodule
bind pv_input_conditioning pv_cond_properties #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) chk (
	.core_clk, .sys_rst, .setup, .setup_write, .raw_pct, .raw_valid, .raw_ready, .pv_out, .pv_valid,
	.pv_ready, .active_decimal, .active_scale_lo);
